// ---- hw/dhp_pkg.sv ----
// Purpose: shared constants of the dual protocol host port
// Assumes: one 40 MHz clock domain
// Notes: local register map reached over the plain register port
package dhp_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h1;
  localparam logic [3:0] OFS_MASK = 4'h2;
  localparam logic [3:0] OFS_RX_DATA = 4'h3;
  localparam logic [3:0] OFS_RX_CMD = 4'h4;
  localparam logic [3:0] OFS_TX_DATA = 4'h5;
  localparam logic [3:0] OFS_STAT_BYTE = 4'h6;
  // config register fields
  localparam int CFG_INT_POL = 0;
  localparam int CFG_BUSY_POL = 1;
  localparam int CFG_BUSY = 2;
  localparam int CFG_SLEEP = 3;
  localparam int CFG_CLK_SEL = 6;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // status event bits
  localparam int EV_DATA_WR = 0;
  localparam int EV_CMD_WR = 1;
  localparam int EV_DATA_RD = 2;
  localparam int EV_STAT_RD = 3;
  // cycle type {cycle_type_select, direction}
  typedef enum logic [1:0] {
    CYC_DATA_WR = 2'b00,
    CYC_DATA_RD = 2'b01,
    CYC_CMD_WR = 2'b10,
    CYC_STAT_RD = 2'b11
  } dhp_cyc_t;
endpackage : dhp_pkg

// ---- hw/dhp_host_port.sv ----
// Purpose: parallel host port, separate-strobe or enable-strobe protocol
// Assumes: host pins are asynchronous and pass two flip-flops first
// Notes: 4-bit mode moves each byte as two nibbles, high nibble first
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] respond only while low select is low and high select is high
// [RULE2] static protocol input picks separate strobes or enable plus direction
// [RULE3] separate-strobe protocol: shared strobe pin is active-low read
// [RULE4] enable-strobe protocol: shared strobe pin is active-high enable
// [RULE5] separate-strobe protocol: second pin is active-low write
// [RULE6] enable-strobe protocol: second pin is direction, high reads
// [RULE7] cycle type from select and direction: data/command write, data/status read
// [RULE8] bus width input: low uses low nibble, high uses full byte
// [RULE9] host leaves upper nibble undriven in 4-bit mode
// [RULE10] interrupt output with configurable active level
// [RULE11] busy output with selectable polarity; host waits while busy
// [RULE12] active-low reset pin fully resets the host port
// [RULE13] clock/sleep output: clock when config bit 6 clear, else sleep
// [RULE14] 4-bit mode: two nibble cycles per byte, high nibble first
// [RULE15] strobes are synchronised and acted on once per assertion
module dhp_host_port (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hard_reset_n,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic cycle_type_select,
  input wire logic protocol_select,
  input wire logic bus_width_select,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  output logic interrupt_out,
  output logic busy_out,
  output logic clk_sleep_out,
  input wire logic [dhp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic data_wr_valid,
  output logic cmd_wr_valid,
  output logic [7:0] wr_byte,
  output logic data_rd_done
);
  import dhp_pkg::*;

  // two-stage synchronisers for all host pins
  logic [14:0] sync1;
  logic [14:0] sync2;
  wire [14:0] pins = {hard_reset_n, chip_select_low_n, chip_select_high,
    read_strobe_n, write_strobe_n, cycle_type_select, protocol_select,
    bus_width_select, data_in[6:0]};
  logic din7_s1;
  logic din7_s2;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1 <= 15'h4000;
      sync2 <= 15'h4000;
      din7_s1 <= 1'b0;
      din7_s2 <= 1'b0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      din7_s1 <= data_in[7];
      din7_s2 <= din7_s1;
    end
  end

  wire hrst_n_s = sync2[14];
  wire csl_n_s = sync2[13];
  wire csh_s = sync2[12];
  wire rd_n_s = sync2[11];
  wire wr_n_s = sync2[10];
  wire cts_s = sync2[9];
  wire proto_s = sync2[8];
  wire width_s = sync2[7];
  wire [7:0] din_s = {din7_s2, sync2[6:0]};

  wire rst_int = sys_rst | ~hrst_n_s; // RULE12

  // registers
  logic [7:0] status_r;
  logic [7:0] config_r;
  logic [7:0] mask_r;
  logic [7:0] rx_cmd;
  logic [7:0] tx_data;
  logic [7:0] stat_byte;
  logic [3:0] nib_hi;
  logic phase;
  logic act_prev;

  wire cs_ok = ~csl_n_s & csh_s; // RULE1
  // RULE2 RULE3 RULE4 RULE5
  wire strobe_on = proto_s ? rd_n_s : (~rd_n_s | ~wr_n_s);
  wire busy = config_r[CFG_BUSY];
  wire act = cs_ok & strobe_on & ~busy; // RULE11
  wire evt = act & ~act_prev; // RULE15
  // direction is the write pin level in both protocols
  wire rw_bit = wr_n_s; // RULE6
  dhp_cyc_t cyc;
  assign cyc = dhp_cyc_t'({cts_s, rw_bit}); // RULE7
  wire is_rd = rw_bit;
  wire byte_end = width_s | phase; // RULE14
  wire rd_read_active = cs_ok & strobe_on & rw_bit;

  // next byte for a write, assembled from nibbles in 4-bit mode
  wire [7:0] in_byte = width_s ? din_s : {nib_hi, din_s[3:0]}; // RULE8
  wire [7:0] src_byte = (cyc == CYC_STAT_RD) ? stat_byte : tx_data;
  wire [7:0] next_dout = width_s ? src_byte :
    {4'h0, (phase ? src_byte[3:0] : src_byte[7:4])}; // RULE14

  wire [7:0] next_ev;
  assign next_ev[EV_DATA_WR] = evt & byte_end & (cyc == CYC_DATA_WR);
  assign next_ev[EV_CMD_WR] = evt & byte_end & (cyc == CYC_CMD_WR);
  assign next_ev[EV_DATA_RD] = evt & byte_end & (cyc == CYC_DATA_RD);
  assign next_ev[EV_STAT_RD] = evt & byte_end & (cyc == CYC_STAT_RD);
  assign next_ev[7:4] = 4'h0;

  // register port decode
  wire wr_status = reg_write & (reg_addr == OFS_STATUS);
  wire wr_config = reg_write & (reg_addr == OFS_CONFIG);
  wire wr_mask = reg_write & (reg_addr == OFS_MASK);
  wire wr_tx = reg_write & (reg_addr == OFS_TX_DATA);
  wire wr_stat = reg_write & (reg_addr == OFS_STAT_BYTE);
  wire [7:0] clr_mask = wr_status ? reg_wdata : 8'h00;
  // set wins over a write-one clear in the same cycle
  wire [7:0] next_status = (status_r & ~clr_mask) | next_ev;
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      OFS_STATUS: rd_mux = status_r;
      OFS_CONFIG: rd_mux = config_r;
      OFS_MASK: rd_mux = mask_r;
      OFS_RX_DATA: rd_mux = wr_byte;
      OFS_RX_CMD: rd_mux = rx_cmd;
      OFS_TX_DATA: rd_mux = tx_data;
      OFS_STAT_BYTE: rd_mux = stat_byte;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst_int) begin
      status_r <= STATUS_RST;
      config_r <= CONFIG_RST;
      mask_r <= MASK_RST;
      tx_data <= BYTE_RST;
      stat_byte <= BYTE_RST;
      reg_rdata <= BYTE_RST;
    end else begin
      status_r <= next_status;
      reg_rdata <= reg_read ? rd_mux : 8'h00;
      if (wr_config) begin
        config_r <= reg_wdata;
      end
      if (wr_mask) begin
        mask_r <= reg_wdata;
      end
      if (wr_tx) begin
        tx_data <= reg_wdata;
      end
      if (wr_stat) begin
        stat_byte <= reg_wdata;
      end
    end
  end

  // host cycle engine
  always_ff @(posedge clock) begin
    if (rst_int) begin
      act_prev <= 1'b0;
      phase <= 1'b0;
      nib_hi <= 4'h0;
      wr_byte <= BYTE_RST;
      rx_cmd <= BYTE_RST;
      data_out <= BYTE_RST;
      data_oe <= 8'h00;
      data_wr_valid <= 1'b0;
      cmd_wr_valid <= 1'b0;
      data_rd_done <= 1'b0;
    end else begin
      act_prev <= act;
      data_wr_valid <= next_ev[EV_DATA_WR];
      cmd_wr_valid <= next_ev[EV_CMD_WR];
      data_rd_done <= next_ev[EV_DATA_RD];
      data_oe <= (rd_read_active & (evt | act_prev)) ?
        (width_s ? 8'hff : 8'h0f) : 8'h00; // RULE8 RULE9
      if (evt) begin
        if (!width_s) begin
          phase <= ~phase; // RULE14
        end
        if (!width_s && !phase && !is_rd) begin
          nib_hi <= din_s[3:0];
        end
        if (is_rd) begin
          data_out <= next_dout;
        end else if (byte_end && !cts_s) begin
          wr_byte <= in_byte;
        end else if (byte_end) begin
          rx_cmd <= in_byte;
        end
      end
    end
  end

  wire irq = |(status_r & mask_r);
  // RULE10
  assign interrupt_out = config_r[CFG_INT_POL] ? irq : ~irq;
  // RULE11
  assign busy_out = config_r[CFG_BUSY_POL] ? busy : ~busy;
  // RULE13
  assign clk_sleep_out = config_r[CFG_CLK_SEL] ? config_r[CFG_SLEEP] : clock;

  // checks
  AST_CS_GATE: assert property ( // RULE1
    @(posedge clock) disable iff (rst_int)
    evt |-> cs_ok)
    else $error("cycle taken without chip select");
  AST_PROTO_STROBE: assert property ( // RULE2
    @(posedge clock) disable iff (rst_int)
    evt |-> (proto_s ? rd_n_s : (!rd_n_s || !wr_n_s)))
    else $error("strobe decode wrong for protocol");
  AST_SEP_READ: assert property ( // RULE3
    @(posedge clock) disable iff (rst_int)
    evt && !proto_s && !rd_n_s |=> data_oe[0])
    else $error("read strobe did not drive data");
  AST_EN_WRITE: assert property ( // RULE4
    @(posedge clock) disable iff (rst_int)
    evt && proto_s && !wr_n_s && cts_s && width_s |=> cmd_wr_valid)
    else $error("enable write not taken");
  AST_EN_LEVEL: assert property ( // RULE4
    @(posedge clock) disable iff (rst_int)
    evt && proto_s |-> rd_n_s)
    else $error("cycle taken with enable low");
  AST_SEP_WRITE: assert property ( // RULE5
    @(posedge clock) disable iff (rst_int)
    evt && !proto_s && !wr_n_s && !cts_s && width_s |=> data_wr_valid)
    else $error("write strobe not taken");
  AST_SEP_LEVEL: assert property ( // RULE5
    @(posedge clock) disable iff (rst_int)
    evt && !proto_s && rd_n_s |-> !wr_n_s)
    else $error("cycle taken with no strobe low");
  AST_DIR_READ: assert property ( // RULE6
    @(posedge clock) disable iff (rst_int)
    evt && proto_s && wr_n_s |=> !data_wr_valid && !cmd_wr_valid)
    else $error("direction high treated as write");
  AST_CMD_TYPE: assert property ( // RULE7
    @(posedge clock) disable iff (rst_int)
    cmd_wr_valid |-> $past(cts_s) && !$past(wr_n_s))
    else $error("command write with wrong select");
  AST_DATA_WR_TYPE: assert property ( // RULE7
    @(posedge clock) disable iff (rst_int)
    data_wr_valid |-> !$past(cts_s) && !$past(wr_n_s))
    else $error("data write with wrong select");
  AST_DATA_RD_TYPE: assert property ( // RULE7
    @(posedge clock) disable iff (rst_int)
    data_rd_done |-> !$past(cts_s) && $past(wr_n_s))
    else $error("data read with wrong select");
  AST_NIBBLE_LANES: assert property ( // RULE8
    @(posedge clock) disable iff (rst_int)
    !$past(width_s) |-> data_oe[7:4] == 4'h0)
    else $error("upper lanes driven in 4-bit mode");
  AST_WIDE_LANES: assert property ( // RULE8
    @(posedge clock) disable iff (rst_int)
    $past(width_s) && data_oe != 8'h00 |-> data_oe == 8'hff)
    else $error("partial lanes driven in 8-bit mode");
  AST_INT_LEVEL: assert property ( // RULE10
    @(posedge clock) disable iff (rst_int)
    (status_r & mask_r) == 8'h00 |-> interrupt_out != config_r[CFG_INT_POL])
    else $error("interrupt active with nothing pending");
  AST_IRQ_ACTIVE: assert property ( // RULE10
    @(posedge clock) disable iff (rst_int)
    (status_r & mask_r) != 8'h00 |-> interrupt_out == config_r[CFG_INT_POL])
    else $error("interrupt idle with event pending");
  AST_SET_WINS: assert property ( // RULE10
    @(posedge clock) disable iff (rst_int)
    next_ev[EV_DATA_WR] |=> status_r[EV_DATA_WR])
    else $error("status event lost");
  AST_BUSY_BLOCK: assert property ( // RULE11
    @(posedge clock) disable iff (rst_int)
    busy |-> !evt)
    else $error("cycle taken while busy");
  AST_HARD_RESET: assert property ( // RULE12
    @(posedge clock) disable iff (sys_rst)
    !hrst_n_s |=> status_r == 8'h00 && data_oe == 8'h00)
    else $error("hard reset did not clear port");
  AST_HARD_CFG: assert property ( // RULE12
    @(posedge clock) disable iff (sys_rst)
    !hrst_n_s |=> config_r == CONFIG_RST && mask_r == MASK_RST)
    else $error("hard reset did not clear settings");
  AST_CLK_SLEEP: assert property ( // RULE13
    @(posedge clock) disable iff (rst_int)
    config_r[CFG_CLK_SEL] |-> clk_sleep_out == config_r[CFG_SLEEP])
    else $error("clock output not showing sleep");
  AST_NIB_FIRST: assert property ( // RULE14
    @(posedge clock) disable iff (rst_int)
    evt && !width_s && !phase && !is_rd |=> !data_wr_valid && !cmd_wr_valid)
    else $error("byte completed on first nibble");
  AST_NIB_SECOND: assert property ( // RULE14
    @(posedge clock) disable iff (rst_int)
    evt && !width_s && phase && !is_rd && !cts_s |=> data_wr_valid)
    else $error("byte not completed on second nibble");
  AST_ONCE: assert property ( // RULE15
    @(posedge clock) disable iff (rst_int)
    evt |=> !evt)
    else $error("strobe acted on twice");
endmodule : dhp_host_port
`default_nettype wire

// ---- verification/dhp_host_model.sv ----
// Purpose: host processor model on the parallel pins
// Assumes: pins settle one clock before the strobe moves
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model (
  input wire logic clock,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  output var logic chip_select_low_n,
  output var logic chip_select_high,
  output var logic read_strobe_n,
  output var logic write_strobe_n,
  output var logic cycle_type_select,
  output var logic protocol_select,
  output var logic bus_width_select,
  output var logic [7:0] data_in
);
  logic [7:0] last_oe;
  initial begin
    chip_select_low_n = 1'b0;
    chip_select_high = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    cycle_type_select = 1'b0;
    protocol_select = 1'b0;
    bus_width_select = 1'b1;
    data_in = 8'h00;
  end
  task automatic set_mode(input logic p, input logic w);
    @(posedge clock);
    protocol_select <= p;
    bus_width_select <= w;
    read_strobe_n <= ~p;
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : set_mode
  task automatic pin_cycle(input logic rd, input logic ct,
                           input logic [7:0] v, output logic [7:0] got);
    @(posedge clock);
    cycle_type_select <= ct;
    data_in <= rd ? ~data_in : v;
    if (protocol_select) write_strobe_n <= rd;
    @(posedge clock);
    if (protocol_select) read_strobe_n <= 1'b1;
    else if (rd) read_strobe_n <= 1'b0;
    else write_strobe_n <= 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    got = data_out;
    last_oe = data_oe;
    @(posedge clock);
    read_strobe_n <= ~protocol_select;
    if (!protocol_select) write_strobe_n <= 1'b1;
    data_in <= ~data_in;
    repeat (6) @(posedge clock);
  endtask : pin_cycle
  task automatic xfer(input logic rd, input logic ct,
                      input logic [7:0] v, output logic [7:0] got);
    logic [7:0] hi;
    logic [7:0] lo;
    if (bus_width_select) begin
      pin_cycle(rd, ct, v, got);
    end else begin
      pin_cycle(rd, ct, {~data_in[7:4], v[7:4]}, hi);
      pin_cycle(rd, ct, {~data_in[7:4], v[3:0]}, lo);
      got = {hi[3:0], lo[3:0]};
    end
  endtask : xfer
endmodule : dhp_host_model
`default_nettype wire

// ---- verification/tb_dhp_host_port.sv ----
// Purpose: self-checking bench of the dual protocol host port
// Assumes: host pins driven by the host model, hard reset pin by the bench
// Notes: pulse outputs are counted by a monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_dhp_host_port;
  import dhp_pkg::*;
  logic clock, sys_rst, hard_reset_n, reg_write, reg_read;
  logic cs_l_n, cs_h, rd_n, wr_n, ct, proto, width;
  logic interrupt_out, busy_out, clk_sleep_out;
  logic data_wr_valid, cmd_wr_valid, data_rd_done;
  logic [7:0] data_in, data_out, data_oe, reg_wdata, reg_rdata, wr_byte, got;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] n_dwr = 8'h00, n_cmd = 8'h00, n_rdd = 8'h00, last_wr;
  int n_errors = 0, n_tests = 0, cyc = 0, p;
  dhp_host_model host (.clock(clock), .data_out(data_out),
    .data_oe(data_oe), .chip_select_low_n(cs_l_n), .chip_select_high(cs_h),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .cycle_type_select(ct),
    .protocol_select(proto), .bus_width_select(width), .data_in(data_in));
  dhp_host_port uut (.clock(clock), .sys_rst(sys_rst),
    .hard_reset_n(hard_reset_n), .chip_select_low_n(cs_l_n),
    .chip_select_high(cs_h), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .cycle_type_select(ct), .protocol_select(proto),
    .bus_width_select(width), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .interrupt_out(interrupt_out), .busy_out(busy_out),
    .clk_sleep_out(clk_sleep_out), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .data_wr_valid(data_wr_valid),
    .cmd_wr_valid(cmd_wr_valid), .wr_byte(wr_byte),
    .data_rd_done(data_rd_done));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (data_wr_valid === 1'b1) n_dwr <= n_dwr + 8'h01;
    if (data_wr_valid === 1'b1) last_wr <= wr_byte;
    if (cmd_wr_valid === 1'b1) n_cmd <= n_cmd + 8'h01;
    if (data_rd_done === 1'b1) n_rdd <= n_rdd + 8'h01;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(negedge clock);
    #2;
  endtask : reg_wr
  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    `CHK(reg_rdata, e)
  endtask : reg_rd
  initial begin
    sys_rst = 1'b1;
    hard_reset_n = 1'b1;
    reg_addr = '0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    reg_rd(OFS_CONFIG, CONFIG_RST);
    reg_rd(OFS_MASK, MASK_RST);
    reg_rd(4'hf, 8'h00);
    `CHK(interrupt_out, 1'b1)
    reg_wr(OFS_MASK, 8'h0f);
    reg_wr(OFS_STAT_BYTE, 8'h5a);
    reg_wr(OFS_TX_DATA, 8'h96);
    for (p = 0; p < 2; p++) begin
      host.set_mode(p[0], 1'b1);
      host.xfer(1'b0, 1'b0, 8'ha5 ^ p[7:0], got);
      `CHK(last_wr, 8'ha5 ^ p[7:0])
      host.xfer(1'b0, 1'b1, 8'h3c, got);
      reg_rd(OFS_RX_CMD, 8'h3c);
      host.xfer(1'b1, 1'b1, 8'h00, got);
      `CHK(got, 8'h5a)
      host.xfer(1'b1, 1'b0, 8'h00, got);
      `CHK({got, host.last_oe}, 16'h96ff)
      `CHK({n_dwr, n_cmd, n_rdd}, {3{p[7:0] + 8'h01}})
    end
    reg_rd(OFS_STATUS, 8'h0f);
    `CHK(interrupt_out, 1'b0)
    reg_wr(OFS_CONFIG, 8'h01);
    `CHK(interrupt_out, 1'b1)
    reg_wr(OFS_STATUS, 8'h0f);
    `CHK(interrupt_out, 1'b0)
    host.chip_select_high <= 1'b0;
    host.xfer(1'b0, 1'b0, 8'h11, got);
    host.chip_select_high <= 1'b1;
    host.chip_select_low_n <= 1'b1;
    host.xfer(1'b0, 1'b0, 8'h11, got);
    host.chip_select_low_n <= 1'b0;
    `CHK(n_dwr, 8'h02)
    host.set_mode(1'b0, 1'b0);
    host.xfer(1'b0, 1'b0, 8'hc3, got);
    `CHK(last_wr, 8'hc3)
    reg_rd(OFS_RX_DATA, 8'hc3);
    host.xfer(1'b1, 1'b0, 8'h00, got);
    `CHK({got, host.last_oe}, 16'h960f)
    host.set_mode(1'b0, 1'b1);
    reg_wr(OFS_CONFIG, 8'h06);
    `CHK(busy_out, 1'b1)
    host.xfer(1'b0, 1'b0, 8'h22, got);
    `CHK(n_dwr, 8'h03)
    reg_wr(OFS_CONFIG, 8'h04);
    `CHK(busy_out, 1'b0)
    reg_wr(OFS_CONFIG, 8'h00);
    `CHK({busy_out, clk_sleep_out}, 2'b10)
    reg_wr(OFS_CONFIG, 8'h48);
    `CHK(clk_sleep_out, 1'b1)
    reg_wr(OFS_CONFIG, 8'h40);
    `CHK(clk_sleep_out, 1'b0)
    hard_reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    hard_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    reg_rd(OFS_CONFIG, CONFIG_RST);
    reg_rd(OFS_STATUS, STATUS_RST);
    reg_rd(OFS_MASK, MASK_RST);
    `CHK({interrupt_out, busy_out}, 2'b11)
    close_out();
  end
endmodule : tb_dhp_host_port
`default_nettype wire
